// ==== include/tpc_pkg.sv ====
package tpc_pkg;

  localparam int ADDR_W = 18;
  localparam int GR_W = 16;

  // Printed offset is not word aligned, so it is kept as an index
  localparam logic [15:0] CTRL_IDX = 16'hfea2;
  localparam logic [15:0] GRA_IDX = 16'hfea4;
  localparam logic [15:0] GRB_IDX = 16'hfea5;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [GR_W-1:0] GR_RST = 16'h0000;

  // Layout of one 4-bit pin field inside the control byte
  localparam int A_LSB = 0;
  localparam int B_LSB = 4;
  localparam int CAP_BIT = 3;
  localparam int INIT_BIT = 2;

  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_ZERO = 2'h1;
  localparam logic [1:0] ACT_ONE = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_CTRL = 2'h1,
    SEL_GRA = 2'h2,
    SEL_GRB = 2'h3
  } tpc_sel_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } tpc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tpc_axi_rsp_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic out;
    logic oe;
  } tpc_pin_state_s;

  localparam tpc_pin_state_s PIN_RST = '0;

endpackage

// ==== src/tpc_pin_ctl.sv ====
`timescale 1ns/100ps
module tpc_pin_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] field,
  input wire logic fieldLoad,
  input wire logic match,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic capture
);

  tpc_pkg::tpc_pin_state_s q;
  tpc_pkg::tpc_pin_state_s d;
  logic rise;
  logic fall;

  always_comb begin
    d = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Level only moves once the two later stages agree
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
    rise = d.lvl & ~q.lvl;
    fall = ~d.lvl & q.lvl;
    capture = 1'b0;
    if (field[tpc_pkg::CAP_BIT]) begin
      // Capture mode releases the pin; the initial-level bit is ignored
      d.oe = 1'b0;
      d.out = 1'b0;
      unique case (field[1:0])
        tpc_pkg::EDGE_RISE: capture = rise;
        tpc_pkg::EDGE_FALL: capture = fall;
        default: capture = rise | fall;
      endcase
    end else begin
      d.oe = (field[1:0] != tpc_pkg::ACT_OFF);
      if (fieldLoad) begin
        d.out = field[tpc_pkg::INIT_BIT];
      end else if (match) begin
        unique case (field[1:0])
          tpc_pkg::ACT_ZERO: d.out = 1'b0;
          tpc_pkg::ACT_ONE: d.out = 1'b1;
          tpc_pkg::ACT_TOGGLE: d.out = ~q.out;
          default: d.out = q.out;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= tpc_pkg::PIN_RST;
    end else begin
      q <= d;
    end
  end

  assign pinOut = q.out;
  assign pinOe = q.oe;

endmodule

// ==== src/tpc_ch5_io.sv ====
// Behaviour
// - A field 0,0: compare, pin starts low; 00 off, 01 low, 10 high, 11 toggle.
// - A field 0,1: same compare actions, but the A pin starts high.
// - A field upper 1: capture from A pin; 00 rise, 01 fall, 1x both.
// - B field uses the same compare encoding for register B and pin B.
// - B field upper 1: capture counter on B pin edges; bit two ignored.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
module tpc_ch5_io (
  input wire logic clk,
  input wire logic rst,
  input wire tpc_pkg::tpc_axi_req_s axiReq,
  output tpc_pkg::tpc_axi_rsp_s axiRsp,
  input wire logic [tpc_pkg::GR_W-1:0] cnt,
  input wire logic cntTick,
  input wire logic pinAIn,
  output logic pinAOut,
  output logic pinAOe,
  input wire logic pinBIn,
  output logic pinBOut,
  output logic pinBOe,
  output logic captureA,
  output logic captureB,
  output logic matchA,
  output logic matchB
);

  typedef struct packed {
    tpc_pkg::tpc_axi_rsp_s rsp;
    logic haveAw;
    logic [tpc_pkg::ADDR_W-1:0] awAddr;
    logic haveW;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [7:0] ctrl;
    logic ctrlLoad;
    logic [tpc_pkg::GR_W-1:0] grA;
    logic [tpc_pkg::GR_W-1:0] grB;
    logic capA;
    logic capB;
    logic mA;
    logic mB;
  } tpc_main_state_s;

  tpc_main_state_s q;
  tpc_main_state_s d;
  logic capEvA;
  logic capEvB;
  logic hitA;
  logic hitB;
  logic [3:0] fieldA;
  logic [3:0] fieldB;

  function automatic tpc_pkg::tpc_sel_e regSel(
    input logic [tpc_pkg::ADDR_W-1:0] addr
  );
    logic [15:0] idx;
    idx = addr[tpc_pkg::ADDR_W-1:2];
    if (idx == tpc_pkg::CTRL_IDX) begin
      regSel = tpc_pkg::SEL_CTRL;
    end else if (idx == tpc_pkg::GRA_IDX) begin
      regSel = tpc_pkg::SEL_GRA;
    end else if (idx == tpc_pkg::GRB_IDX) begin
      regSel = tpc_pkg::SEL_GRB;
    end else begin
      regSel = tpc_pkg::SEL_NONE;
    end
  endfunction

  assign fieldA = q.ctrl[tpc_pkg::A_LSB +: 4];
  assign fieldB = q.ctrl[tpc_pkg::B_LSB +: 4];
  assign hitA = cntTick && (cnt == q.grA) && !fieldA[tpc_pkg::CAP_BIT];
  assign hitB = cntTick && (cnt == q.grB) && !fieldB[tpc_pkg::CAP_BIT];

  always_comb begin
    d = q;
    d.ctrlLoad = 1'b0;
    if (axiReq.awvalid && q.rsp.awready) begin
      d.haveAw = 1'b1;
      d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && q.rsp.wready) begin
      d.haveW = 1'b1;
      d.wData = axiReq.wdata;
      d.wStrb = axiReq.wstrb;
    end
    if (q.rsp.bvalid && axiReq.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (q.haveAw && q.haveW && !q.rsp.bvalid) begin
      d.haveAw = 1'b0;
      d.haveW = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = tpc_pkg::RESP_OKAY;
      unique case (regSel(q.awAddr))
        tpc_pkg::SEL_CTRL: begin
          if (q.wStrb[0]) begin
            d.ctrl = q.wData[7:0];
            d.ctrlLoad = 1'b1;
          end
        end
        tpc_pkg::SEL_GRA: begin
          if (q.wStrb[0]) d.grA[7:0] = q.wData[7:0];
          if (q.wStrb[1]) d.grA[15:8] = q.wData[15:8];
        end
        tpc_pkg::SEL_GRB: begin
          if (q.wStrb[0]) d.grB[7:0] = q.wData[7:0];
          if (q.wStrb[1]) d.grB[15:8] = q.wData[15:8];
        end
        tpc_pkg::SEL_NONE: d.rsp.bresp = tpc_pkg::RESP_SLVERR;
      endcase
    end
    // Hardware capture wins over a software write in the same cycle
    if (capEvA) d.grA = cnt;
    if (capEvB) d.grB = cnt;
    d.capA = capEvA;
    d.capB = capEvB;
    d.mA = hitA;
    d.mB = hitB;
    if (axiReq.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = tpc_pkg::RESP_OKAY;
      d.rsp.rdata = 32'h0000_0000;
      unique case (regSel(axiReq.araddr))
        tpc_pkg::SEL_CTRL: d.rsp.rdata[7:0] = q.ctrl;
        tpc_pkg::SEL_GRA: d.rsp.rdata[15:0] = q.grA;
        tpc_pkg::SEL_GRB: d.rsp.rdata[15:0] = q.grB;
        tpc_pkg::SEL_NONE: d.rsp.rresp = tpc_pkg::RESP_SLVERR;
      endcase
    end else if (q.rsp.rvalid && axiReq.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    d.rsp.awready = !d.haveAw;
    d.rsp.wready = !d.haveW;
    d.rsp.arready = !d.rsp.rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= tpc_pkg::CTRL_RST;
      q.grA <= tpc_pkg::GR_RST;
      q.grB <= tpc_pkg::GR_RST;
    end else begin
      q <= d;
    end
  end

  tpc_pin_ctl u_pinA (
    .clk(clk),
    .rst(rst),
    .field(fieldA),
    .fieldLoad(q.ctrlLoad),
    .match(hitA),
    .pinIn(pinAIn),
    .pinOut(pinAOut),
    .pinOe(pinAOe),
    .capture(capEvA)
  );

  tpc_pin_ctl u_pinB (
    .clk(clk),
    .rst(rst),
    .field(fieldB),
    .fieldLoad(q.ctrlLoad),
    .match(hitB),
    .pinIn(pinBIn),
    .pinOut(pinBOut),
    .pinOe(pinBOe),
    .capture(capEvB)
  );

  assign axiRsp = q.rsp;
  assign captureA = q.capA;
  assign captureB = q.capB;
  assign matchA = q.mA;
  assign matchB = q.mB;

  property p_initLow;
    @(posedge clk) disable iff (rst)
      q.ctrlLoad && q.ctrl[3:2] == 2'h0 && q.ctrl[1:0] != 2'h0
      |=> pinAOe && !pinAOut;
  endproperty
  a_initLow: assert property (p_initLow)
    else $error("pin A did not start low");

  property p_initHigh;
    @(posedge clk) disable iff (rst)
      q.ctrlLoad && q.ctrl[3:2] == 2'h1 && q.ctrl[1:0] != 2'h0
      |=> pinAOe && pinAOut;
  endproperty
  a_initHigh: assert property (p_initHigh)
    else $error("pin A did not start high");

  property p_toggleA;
    @(posedge clk) disable iff (rst)
      hitA && fieldA[1:0] == 2'h3 && !q.ctrlLoad
      |=> pinAOut != $past(pinAOut);
  endproperty
  a_toggleA: assert property (p_toggleA)
    else $error("pin A did not toggle on match");

  property p_capA;
    @(posedge clk) disable iff (rst)
      capEvA |=> q.grA == $past(cnt) ##0 captureA;
  endproperty
  a_capA: assert property (p_capA)
    else $error("register A missed the captured count");

  property p_noCapA;
    @(posedge clk) disable iff (rst)
      (!fieldA[3] |-> !capEvA) and (fieldA[3] |=> !pinAOe);
  endproperty
  a_noCapA: assert property (p_noCapA)
    else $error("pin A capture in wrong mode");

  property p_matchB;
    @(posedge clk) disable iff (rst)
      hitB && fieldB[1:0] == 2'h2 && !q.ctrlLoad |=> pinBOut ##0 matchB;
  endproperty
  a_matchB: assert property (p_matchB)
    else $error("pin B not driven high on match");

  property p_capB;
    @(posedge clk) disable iff (rst)
      capEvB |-> fieldB[3] ##1 (q.grB == $past(cnt) && !pinBOe);
  endproperty
  a_capB: assert property (p_capB)
    else $error("register B capture wrong");

  property p_initNow;
    @(posedge clk) disable iff (rst)
      q.ctrlLoad && !q.ctrl[7] && q.ctrl[5:4] != 2'h0
      |=> pinBOe && pinBOut == $past(q.ctrl[6]);
  endproperty
  a_initNow: assert property (p_initNow)
    else $error("pin B initial level late");

endmodule

// ==== testbench/tpc_pin_model.sv ====
`timescale 1ns/100ps
module tpc_pin_model (
  input wire logic oe,
  input wire logic out,
  input wire logic drv,
  output logic pinIn
);
  // No pull on the pin: once released, the outside driver sets it
  assign pinIn = oe ? out : drv;
endmodule

// ==== testbench/tpc_ch5_io_test.sv ====
`timescale 1ns/100ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin failCount++; \
  $display("wrong value at %0t: %0h vs %0h", $time, (a), (e)); end end
module tpc_ch5_io_test;
  localparam logic [17:0] CTRL_A = {tpc_pkg::CTRL_IDX, 2'h0};
  localparam logic [17:0] GRA_A = {tpc_pkg::GRA_IDX, 2'h0};
  localparam logic [17:0] GRB_A = {tpc_pkg::GRB_IDX, 2'h0};
  localparam logic [1:0] OK = tpc_pkg::RESP_OKAY;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tpc_pkg::tpc_axi_req_s req = '0;
  tpc_pkg::tpc_axi_rsp_s rsp;
  logic [15:0] cnt = 16'h0;
  logic cntTick = 1'b0;
  logic drvA = 1'b0;
  logic drvB = 1'b0;
  logic pinAIn, pinAOut, pinAOe, pinBIn, pinBOut, pinBOe;
  logic capA, capB, matchA, matchB;
  int failCount = 0;
  int nCompared = 0;
  int nCapA = 0;
  int nCapB = 0;
  int nMat = 0;

  always #50 clk = ~clk;
  // Counted on the falling edge so the bench never races the pulses
  always @(negedge clk) begin
    if (capA === 1'b1) nCapA++;
    if (capB === 1'b1) nCapB++;
    if (matchA === 1'b1 && matchB === 1'b1) nMat++;
  end

  tpc_ch5_io tpc_ch5_io_inst (.clk(clk), .rst(rst), .axiReq(req),
    .axiRsp(rsp), .cnt(cnt), .cntTick(cntTick), .pinAIn(pinAIn),
    .pinAOut(pinAOut), .pinAOe(pinAOe), .pinBIn(pinBIn), .pinBOut(pinBOut),
    .pinBOe(pinBOe), .captureA(capA), .captureB(capB), .matchA(matchA),
    .matchB(matchB));
  tpc_pin_model pin_a_inst (.oe(pinAOe), .out(pinAOut), .drv(drvA),
    .pinIn(pinAIn));
  tpc_pin_model pin_b_inst (.oe(pinBOe), .out(pinBOut), .drv(drvB),
    .pinIn(pinBIn));

  task wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] r);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    `CHK(rsp.bresp, r)
    // Let an edge pass so a next call never reassigns bready in this step
    @(posedge clk);
  endtask

  task rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    `CHK(rsp.rdata, e)
    `CHK(rsp.rresp, r)
    @(posedge clk);
  endtask

  task t_reset_map;
    rd(CTRL_A, 32'h0, OK);
    `CHK({pinAOe, pinBOe}, 2'h0)
    wr(18'h3fa8c, 32'hff, tpc_pkg::RESP_SLVERR);
    rd(18'h3fa8c, 32'h0, tpc_pkg::RESP_SLVERR);
    wr(GRA_A, 32'h5, OK);
    wr(GRB_A, 32'h5, OK);
    rd(GRB_A, 32'h5, OK);
    $display("reset and map done");
  endtask

  task t_compare;
    logic [3:0] f;
    logic [1:0] ac;
    logic lv;
    for (int i = 0; i < 8; i++) begin
      f = i[3:0];
      ac = f[1:0];
      lv = f[2];
      wr(CTRL_A, {24'h0, f, f}, OK);
      #1;
      `CHK({pinAOe, pinBOe}, {2{ac != 2'h0}})
      if (ac != 2'h0) `CHK({pinAOut, pinBOut}, {lv, lv})
      @(posedge clk);
      cnt <= 16'h5;
      cntTick <= 1'b1;
      @(posedge clk);
      cntTick <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      if (ac == 2'h1) `CHK({pinAOut, pinBOut}, 2'h0)
      if (ac == 2'h2) `CHK({pinAOut, pinBOut}, 2'h3)
      if (ac == 2'h3) `CHK({pinAOut, pinBOut}, {~lv, ~lv})
      `CHK({pinAOe, pinBOe}, {2{ac != 2'h0}})
      `CHK(nMat, i + 1)
      @(posedge clk);
    end
    $display("compare modes done");
  endtask

  task t_capture;
    logic [3:0] m;
    int ca, cb;
    for (int i = 8; i < 16; i++) begin
      m = i[3:0];
      wr(CTRL_A, {24'h0, m, m}, OK);
      cnt <= 16'h100 + 16'(i);
      repeat (6) @(posedge clk);
      #1;
      `CHK({pinAOe, pinBOe}, 2'h0)
      ca = nCapA;
      cb = nCapB;
      @(posedge clk);
      drvA <= 1'b1;
      drvB <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK(nCapA - ca, int'(!m[0] || m[1]))
      `CHK(nCapB - cb, int'(!m[0] || m[1]))
      drvA <= 1'b0;
      drvB <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(nCapA - ca, 1 + int'(m[1]))
      `CHK(nCapB - cb, 1 + int'(m[1]))
      rd(GRA_A, 32'h100 + i, OK);
      rd(GRB_A, 32'h100 + i, OK);
    end
    $display("capture modes done");
  endtask

  task summarize;
    $display("compared %0d, failed %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_map();
    t_compare();
    t_capture();
    summarize();
  end
endmodule
